/* File: src/host_port_map.svh */
// Purpose: Constants for the shared host-port pin roles
// Assumes: Mode 3 SPI framing on the shared pins
// Notes:   Strap codes differ from the two-bit interface-mode values and are decoded to them
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH

`define STRAP_SPI_SLAVE  2'b10
`define STRAP_SPI_MASTER 2'b11
`define STRAP_RESET_VAL  2'b00
`define SPI_BIT_LAST     3'h7
`define SPI_BITS_DONE    4'h8
`define SPI_IDLE_FILL    8'hff
`define SCLK_HALF_DEF    4

`endif

/* File: src/host_port_pkg.sv */
// Purpose: Types for the shared host-port pin roles
// Assumes: Used with host_port_map.svh
// Notes:   Mode codes are Gray along reset, master, slave
package host_port_pkg;

   typedef enum logic [1:0] {
      MODE_WAIT       = 2'b00,
      MODE_SPI_MASTER = 2'b01,
      MODE_SPI_SLAVE  = 2'b11,
      MODE_I2C        = 2'b10
   } iface_mode_t;

   typedef struct packed {
      logic out;
      logic oe;
   } pin_drive_t;

endpackage : host_port_pkg

/* File: src/host_port_pin_roles.sv */
// Purpose: Role assignment and serial engines for the shared host-interface pins
// Assumes: mclk_in 50 MHz; link_sclk_in is the SCLK pin level, clocking slave logic
// Notes:   No registers reach software; status and mode are plain outputs
`include "host_port_map.svh"
`timescale 1ns/10ps
`default_nettype none

module host_port_pin_roles #(
   parameter int SCLK_HALF_CYC = `SCLK_HALF_DEF
) (
   input  wire logic                        mclk_in,
   input  wire logic                        rst_in,
   input  wire logic                        chip_reset_low_in,
   input  wire logic                        link_sclk_in,
   input  wire logic                        sclk_pin_in,
   output host_port_pkg::pin_drive_t        sclk_drive_out,
   input  wire logic                        sda_mosi_pin_in,
   output host_port_pkg::pin_drive_t        sda_mosi_drive_out,
   input  wire logic                        miso_pin_in,
   output host_port_pkg::pin_drive_t        miso_drive_out,
   input  wire logic                        host_select_low_pin_in,
   output host_port_pkg::pin_drive_t        host_select_low_drive_out,
   output host_port_pkg::iface_mode_t       iface_mode_out,
   output logic [1:0]                       strap_capture_status_out,
   output logic                             i2c_scl_level_out,
   output logic                             i2c_sda_level_out,
   input  wire logic                        i2c_sda_pull_low_in,
   input  wire logic [7:0]                  master_tx_byte_in,
   input  wire logic                        master_start_in,
   output logic                             master_busy_out,
   output logic                             master_done_out,
   output logic [7:0]                       master_rx_byte_out,
   input  wire logic                        autocfg_done_in,
   input  wire logic [7:0]                  slave_tx_byte_in,
   input  wire logic                        slave_tx_valid_in,
   output logic                             slave_tx_ready_out,
   output logic [7:0]                       slave_rx_byte_out,
   output logic                             slave_rx_valid_out
);

   // ----------------------------------------------------------------
   // Pin synchronisers (core clock)
   // ----------------------------------------------------------------
   logic       chip_reset_low_s1, chip_reset_low_s2, chip_reset_low_s3;
   logic       miso_s1, miso_s2;
   logic       csn_s1, csn_s2;
   logic       scl_s1, scl_s2;
   logic       sda_s1, sda_s2;

   always_ff @(posedge mclk_in) begin
      chip_reset_low_s1 <= chip_reset_low_in;
      chip_reset_low_s2 <= chip_reset_low_s1;
      chip_reset_low_s3 <= chip_reset_low_s2;
      miso_s1 <= miso_pin_in;
      miso_s2 <= miso_s1;
      csn_s1  <= host_select_low_pin_in;
      csn_s2  <= csn_s1;
      scl_s1  <= sclk_pin_in;
      scl_s2  <= scl_s1;
      sda_s1  <= sda_mosi_pin_in;
      sda_s2  <= sda_s1;
   end

   // Straps ride the same two stages as the reset pin, so they line up
   logic core_rst;
   logic reset_release;
   assign core_rst      = rst_in | ~chip_reset_low_s2;
   assign reset_release = chip_reset_low_s2 & ~chip_reset_low_s3;

   function automatic host_port_pkg::iface_mode_t decode_strap(input logic [1:0] strap);
      host_port_pkg::iface_mode_t m;
      m = host_port_pkg::MODE_I2C;
      if (strap == `STRAP_SPI_SLAVE) begin
         m = host_port_pkg::MODE_SPI_SLAVE;
      end else if (strap == `STRAP_SPI_MASTER) begin
         m = host_port_pkg::MODE_SPI_MASTER;
      end
      return m;
   endfunction : decode_strap

   // ----------------------------------------------------------------
   // Strap capture and mode
   // ----------------------------------------------------------------
   host_port_pkg::iface_mode_t mode_reg;
   logic [1:0]                 strap_reg;

   always_ff @(posedge mclk_in) begin
      if (core_rst) begin
         mode_reg  <= host_port_pkg::MODE_WAIT;
         strap_reg <= `STRAP_RESET_VAL;
      end else if (reset_release) begin
         strap_reg <= {miso_s2, csn_s2};
         mode_reg  <= decode_strap({miso_s2, csn_s2});
      end else if (mode_reg == host_port_pkg::MODE_SPI_MASTER && autocfg_done_in) begin
         mode_reg <= host_port_pkg::MODE_SPI_SLAVE;
      end
   end

   always_ff @(posedge mclk_in) begin
      iface_mode_out           <= mode_reg;
      strap_capture_status_out <= strap_reg;
      i2c_scl_level_out        <= scl_s2;
      i2c_sda_level_out        <= sda_s2;
   end

   // ----------------------------------------------------------------
   // SPI master engine and core-driven pins
   // ----------------------------------------------------------------
   // Half period must be at least 2 cycles so the synchronised MISO
   // level has settled when it is sampled at the end of the high phase.
   localparam int HALF_LAST = SCLK_HALF_CYC - 1;

   logic       in_master;
   logic       half_wrap;
   logic [7:0] div_reg;
   logic [3:0] mbit_reg;
   logic [7:0] mtx_reg;
   logic [7:0] mrx_reg;
   logic       msclk_reg;
   logic       mmosi_reg;

   assign in_master = (mode_reg == host_port_pkg::MODE_SPI_MASTER);
   assign half_wrap = (div_reg == 8'(HALF_LAST));

   always_ff @(posedge mclk_in) begin
      master_done_out <= 1'b0;
      if (core_rst || !in_master) begin
         // Leaving master mode keeps the last byte readable
         if (core_rst) begin
            master_rx_byte_out <= 8'h00;
         end
         master_busy_out <= 1'b0;
         div_reg         <= 8'h00;
         mbit_reg        <= 4'h0;
         msclk_reg       <= 1'b1;
         mmosi_reg       <= 1'b1;
         mtx_reg         <= 8'h00;
         mrx_reg         <= 8'h00;
      end else if (!master_busy_out) begin
         if (master_start_in) begin
            master_busy_out <= 1'b1;
            mtx_reg         <= master_tx_byte_in;
            mbit_reg        <= 4'h0;
            div_reg         <= 8'h00;
         end
      end else if (!half_wrap) begin
         div_reg <= div_reg + 8'h01;
      end else begin
         div_reg <= 8'h00;
         if (msclk_reg) begin
            if (mbit_reg != 4'h0) begin
               mrx_reg <= {mrx_reg[6:0], miso_s2};
            end
            if (mbit_reg == `SPI_BITS_DONE) begin
               master_busy_out    <= 1'b0;
               master_done_out    <= 1'b1;
               master_rx_byte_out <= {mrx_reg[6:0], miso_s2};
            end else begin
               msclk_reg <= 1'b0;
               mmosi_reg <= mtx_reg[7];
               mtx_reg   <= {mtx_reg[6:0], 1'b0};
            end
         end else begin
            msclk_reg <= 1'b1;
            mbit_reg  <= mbit_reg + 4'h1;
         end
      end
   end

   always_ff @(posedge mclk_in) begin
      if (core_rst) begin
         sclk_drive_out            <= '{out: 1'b1, oe: 1'b0};
         sda_mosi_drive_out        <= '{out: 1'b1, oe: 1'b0};
         host_select_low_drive_out <= '{out: 1'b1, oe: 1'b0};
      end else begin
         sclk_drive_out            <= '{out: msclk_reg, oe: in_master};
         host_select_low_drive_out <= '{out: 1'b0, oe: in_master};
         if (in_master) begin
            sda_mosi_drive_out <= '{out: mmosi_reg, oe: 1'b1};
         end else if (mode_reg == host_port_pkg::MODE_I2C) begin
            sda_mosi_drive_out <= '{out: 1'b0, oe: i2c_sda_pull_low_in};
         end else begin
            sda_mosi_drive_out <= '{out: 1'b1, oe: 1'b0};
         end
      end
   end

   // ----------------------------------------------------------------
   // Slave transmit hand-off to the link (core side)
   // ----------------------------------------------------------------
   logic       tx_req_reg;
   logic [7:0] tx_hold_reg;
   logic       tx_ack_l;
   logic       tx_ack_s1, tx_ack_s2;
   logic       tx_accept;

   assign tx_accept = slave_tx_ready_out & slave_tx_valid_in;

   always_ff @(posedge mclk_in) begin
      tx_ack_s1 <= tx_ack_l;
      tx_ack_s2 <= tx_ack_s1;
      if (core_rst) begin
         tx_req_reg         <= 1'b0;
         tx_hold_reg        <= `SPI_IDLE_FILL;
         slave_tx_ready_out <= 1'b0;
      end else begin
         if (tx_accept) begin
            tx_req_reg  <= ~tx_req_reg;
            tx_hold_reg <= slave_tx_byte_in;
         end
         slave_tx_ready_out <= !tx_accept && (tx_req_reg == tx_ack_s2)
                               && (mode_reg == host_port_pkg::MODE_SPI_SLAVE);
      end
   end

   // ----------------------------------------------------------------
   // Slave receive event from the link (core side)
   // ----------------------------------------------------------------
   // Byte word is read three core cycles after its toggle; the link needs
   // eight more SCLK edges before it can overwrite it.
   logic       rx_tgl_l;
   logic [7:0] rx_byte_l;
   logic       rx_tgl_s1, rx_tgl_s2, rx_tgl_s3;

   always_ff @(posedge mclk_in) begin
      rx_tgl_s1 <= rx_tgl_l;
      rx_tgl_s2 <= rx_tgl_s1;
      rx_tgl_s3 <= rx_tgl_s2;
      if (core_rst) begin
         slave_rx_valid_out <= 1'b0;
         slave_rx_byte_out  <= 8'h00;
      end else begin
         slave_rx_valid_out <= (rx_tgl_s2 ^ rx_tgl_s3) && (mode_reg == host_port_pkg::MODE_SPI_SLAVE);
         if (rx_tgl_s2 ^ rx_tgl_s3) begin
            slave_rx_byte_out <= rx_byte_l;
         end
      end
   end

   // ----------------------------------------------------------------
   // Link domain: slave shift logic on the external SCLK
   // ----------------------------------------------------------------
   // Mode 3 framing: SCLK idles high, so the first edge of a frame is
   // falling and MISO can be launched from a flip-flop in time.
   logic [2:0] lbit_reg;
   logic [7:0] lrx_reg;
   logic       lmode_s1, lmode_s2;
   logic       ltx_req_s1, ltx_req_s2;
   logic [7:0] ltx_reg;
   logic       tx_fresh;

   always_ff @(posedge link_sclk_in or posedge host_select_low_pin_in) begin
      if (host_select_low_pin_in) begin
         lbit_reg <= 3'h0;
         lrx_reg  <= 8'h00;
      end else begin
         lbit_reg <= lbit_reg + 3'h1;
         lrx_reg  <= {lrx_reg[6:0], sda_mosi_pin_in};
      end
   end

   always_ff @(posedge link_sclk_in or negedge chip_reset_low_in) begin
      if (!chip_reset_low_in) begin
         rx_tgl_l  <= 1'b0;
         rx_byte_l <= 8'h00;
      end else if (!host_select_low_pin_in && lbit_reg == `SPI_BIT_LAST) begin
         rx_tgl_l  <= ~rx_tgl_l;
         rx_byte_l <= {lrx_reg[6:0], sda_mosi_pin_in};
      end
   end

   always_ff @(negedge link_sclk_in or negedge chip_reset_low_in) begin
      if (!chip_reset_low_in) begin
         lmode_s1   <= 1'b0;
         lmode_s2   <= 1'b0;
         ltx_req_s1 <= 1'b0;
         ltx_req_s2 <= 1'b0;
         tx_ack_l   <= 1'b0;
      end else begin
         lmode_s1   <= (mode_reg == host_port_pkg::MODE_SPI_SLAVE);
         lmode_s2   <= lmode_s1;
         ltx_req_s1 <= tx_req_reg;
         ltx_req_s2 <= ltx_req_s1;
         if (!host_select_low_pin_in && lbit_reg == 3'h0 && tx_fresh) begin
            tx_ack_l <= ~tx_ack_l;
         end
      end
   end

   assign tx_fresh = (ltx_req_s2 != tx_ack_l);

   always_ff @(negedge link_sclk_in or posedge host_select_low_pin_in or negedge chip_reset_low_in) begin
      if (!chip_reset_low_in || host_select_low_pin_in) begin
         ltx_reg        <= `SPI_IDLE_FILL;
         miso_drive_out <= '{out: 1'b1, oe: 1'b0};
      end else if (lbit_reg == 3'h0) begin
         ltx_reg        <= tx_fresh ? {tx_hold_reg[6:0], 1'b1} : `SPI_IDLE_FILL;
         miso_drive_out <= '{out: (tx_fresh ? tx_hold_reg[7] : 1'b1), oe: lmode_s2};
      end else begin
         ltx_reg        <= {ltx_reg[6:0], 1'b1};
         miso_drive_out <= '{out: ltx_reg[7], oe: lmode_s2};
      end
   end

endmodule : host_port_pin_roles

`default_nettype wire

/* File: dv/host_port_pin_roles_sva.sv */
// Purpose: Port checks for the host pin roles
// Assumes: Bound to the block top; mclk domain only
// Notes:   Link-side timing is judged where it reaches the pins
`timescale 1ns/10ps
`default_nettype none
module host_port_pin_roles_sva #(parameter int SCLK_HALF_CYC = 4) (
   input wire logic                       mclk_in,
   input wire logic                       rst_in,
   input wire logic                       chip_reset_low_in,
   input wire logic                       miso_pin_in,
   input wire logic                       host_select_low_pin_in,
   input wire logic                       i2c_sda_pull_low_in,
   input wire logic                       master_start_in,
   input wire logic                       master_busy_out,
   input wire logic                       master_done_out,
   input wire logic                       autocfg_done_in,
   input wire host_port_pkg::pin_drive_t  sclk_drive_out,
   input wire host_port_pkg::pin_drive_t  sda_mosi_drive_out,
   input wire host_port_pkg::pin_drive_t  miso_drive_out,
   input wire host_port_pkg::pin_drive_t  host_select_low_drive_out,
   input wire host_port_pkg::iface_mode_t iface_mode_out,
   input wire logic [1:0]                 strap_capture_status_out
);
   localparam int DONE_LO = 17 * SCLK_HALF_CYC - 2;
   localparam int DONE_HI = 17 * SCLK_HALF_CYC + 3;
   logic       mst;
   logic       i2c;
   logic [1:0] seen_reg;
   assign mst = iface_mode_out == host_port_pkg::MODE_SPI_MASTER;
   assign i2c = iface_mode_out == host_port_pkg::MODE_I2C;
   // Straps as the pins showed them at release
   always_ff @(posedge mclk_in) begin
      if ($rose(chip_reset_low_in)) begin
         seen_reg <= {miso_pin_in, host_select_low_pin_in};
      end
   end
   default clocking @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);
   chk_strap_latch: assert property ($rose(chip_reset_low_in) |=> ##[2:5]
      strap_capture_status_out == seen_reg) else $error("strap status wrong");
   chk_master_code: assert property (mst && $stable(strap_capture_status_out)
      |-> strap_capture_status_out == 2'h3) else $error("master mode bad strap");
   chk_i2c_code: assert property (i2c && $stable(strap_capture_status_out)
      |-> !strap_capture_status_out[1]) else $error("i2c mode bad strap");
   chk_reset_float: assert property ((!chip_reset_low_in) [*4] |-> !(sclk_drive_out.oe
      || sda_mosi_drive_out.oe || miso_drive_out.oe || host_select_low_drive_out.oe))
      else $error("pin driven in reset");
   chk_scl_free: assert property (sclk_drive_out.oe |-> mst || $past(mst))
      else $error("clock driven outside master");
   chk_sda_open: assert property (chip_reset_low_in && i2c && $past(i2c) |-> !sda_mosi_drive_out.out
      && sda_mosi_drive_out.oe == $past(i2c_sda_pull_low_in)) else $error("data not open drain");
   chk_master_pins: assert property (mst && $past(mst) && chip_reset_low_in |->
      sclk_drive_out.oe && sda_mosi_drive_out.oe && host_select_low_drive_out.oe
      && !host_select_low_drive_out.out && !miso_drive_out.oe) else $error("master roles wrong");
   chk_cs_release: assert property (mst && autocfg_done_in |-> ##[1:4] !host_select_low_drive_out.oe)
      else $error("select not released");
   chk_byte_time: assert property (mst && !master_busy_out && master_start_in && !autocfg_done_in
      |-> ##[DONE_LO:DONE_HI] master_done_out) else $error("byte time wrong");
   chk_miso_select: assert property (host_select_low_pin_in && $past(host_select_low_pin_in)
      |-> !miso_drive_out.oe) else $error("miso driven deselected");
   chk_miso_role: assert property (miso_drive_out.oe |-> iface_mode_out == host_port_pkg::MODE_SPI_SLAVE)
      else $error("miso driven outside slave");
endmodule : host_port_pin_roles_sva
`default_nettype wire

/* File: dv/host_port_far_end.sv */
// Purpose: Far side of the host pins: serial memory or external master
// Assumes: Mode 3 framing; pull-ups resolved in the bench
// Notes:   Its clock runs only inside frames, 48 ns period
`timescale 1ns/10ps
`default_nettype none
module host_port_far_end (
   input  wire logic                    sclk_w_in,
   input  wire logic                    mosi_w_in,
   input  wire logic                    miso_w_in,
   input  wire logic                    cs_w_in,
   output var host_port_pkg::pin_drive_t miso_drv_out,
   output var host_port_pkg::pin_drive_t sclk_drv_out,
   output var host_port_pkg::pin_drive_t mosi_drv_out,
   output var host_port_pkg::pin_drive_t cs_drv_out,
   output logic [7:0]                   got_out
);
   logic [7:0] rom_reg = 8'h5a;
   initial begin
      miso_drv_out = '0;
      sclk_drv_out = '0;
      mosi_drv_out = '0;
      cs_drv_out = '0;
      got_out = 8'h00;
   end
   // Memory answers only while the block owns the clock
   always @(negedge sclk_w_in) begin
      if (!cs_w_in && !sclk_drv_out.oe) begin
         miso_drv_out <= {rom_reg[7], 1'b1};
         rom_reg <= {rom_reg[6:0], 1'b1};
      end
   end
   always @(posedge sclk_w_in) begin
      if (!cs_w_in) begin
         got_out <= {got_out[6:0], mosi_w_in};
      end
   end
   always @(posedge cs_w_in) begin
      miso_drv_out.oe <= 1'b0;
   end
   // Clock stands high between frames
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      rx = 8'h00;
      #7 cs_drv_out = 2'b01;
      sclk_drv_out = 2'b11;
      mosi_drv_out.oe = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         #24 sclk_drv_out.out = 1'b0;
         mosi_drv_out.out = tx[i];
         #24 sclk_drv_out.out = 1'b1;
         rx = {rx[6:0], miso_w_in};
      end
      #24 cs_drv_out.out = 1'b1;
      sclk_drv_out.oe = 1'b0;
      mosi_drv_out.oe = 1'b0;
      #24 cs_drv_out.oe = 1'b0;
   endtask : xfer
endmodule : host_port_far_end
`default_nettype wire

/* File: dv/host_port_pin_roles_bench.sv */
// Purpose: Self-checking bench for the host pin roles
// Assumes: Pull-ups on SCLK and MOSI; MISO and select rest at bench strap levels
// Notes:   Byte half-period shortened to 3 cycles
`timescale 1ns/10ps
`default_nettype none
module host_port_pin_roles_bench;
   typedef struct {
      logic [1:0]                 strap;
      logic                       pull;
      host_port_pkg::iface_mode_t mode;
      logic                       sda_oe;
   } row_t;
   row_t rows [4] = '{'{2'h0, 1'b1, host_port_pkg::MODE_I2C, 1'b1},
      '{2'h1, 1'b0, host_port_pkg::MODE_I2C, 1'b0}, '{2'h2, 1'b1, host_port_pkg::MODE_SPI_SLAVE, 1'b0},
      '{2'h3, 1'b0, host_port_pkg::MODE_SPI_MASTER, 1'b1}};
   logic                       mclk = 1'b0;
   logic                       rst = 1'b1;
   logic                       chip_n = 1'b1;
   logic                       pull_lo = 1'b0;
   logic                       acfg = 1'b0;
   logic                       mstart = 1'b0;
   logic                       stv = 1'b0;
   logic [1:0]                 strap = 2'h0;
   logic [7:0]                 mtx = 8'h00;
   logic [7:0]                 stx = 8'h00;
   logic [7:0]                 rx, got, m_rx, s_rx;
   logic [1:0]                 status;
   logic                       busy, done, tx_ready, scl_lvl, sda_lvl, s_valid;
   host_port_pkg::iface_mode_t mode;
   host_port_pkg::pin_drive_t  sclk_d, sda_d, miso_d, cs_d, p_sclk, p_mosi, p_miso, p_cs;
   wire logic                  sclk_w, mosi_w, miso_w, cs_w;
   int                         fail_count = 0;
   int                         compares = 0;
   int                         cycles = 0;
   int                         rx_seen = 0;
   assign sclk_w = sclk_d.oe ? sclk_d.out : (p_sclk.oe ? p_sclk.out : 1'b1);
   assign mosi_w = (sda_d.oe ? sda_d.out : 1'b1) & (p_mosi.oe ? p_mosi.out : 1'b1);
   assign miso_w = miso_d.oe ? miso_d.out : (p_miso.oe ? p_miso.out : strap[1]);
   assign cs_w = cs_d.oe ? cs_d.out : (p_cs.oe ? p_cs.out : strap[0]);
   always #10 mclk = ~mclk;
   host_port_pin_roles #(.SCLK_HALF_CYC(3)) uut (.mclk_in(mclk), .rst_in(rst), .chip_reset_low_in(chip_n),
      .link_sclk_in(sclk_w), .sclk_pin_in(sclk_w), .sclk_drive_out(sclk_d), .sda_mosi_pin_in(mosi_w),
      .sda_mosi_drive_out(sda_d), .miso_pin_in(miso_w), .miso_drive_out(miso_d), .host_select_low_pin_in(cs_w),
      .host_select_low_drive_out(cs_d), .iface_mode_out(mode), .strap_capture_status_out(status),
      .i2c_scl_level_out(scl_lvl), .i2c_sda_level_out(sda_lvl), .i2c_sda_pull_low_in(pull_lo),
      .master_tx_byte_in(mtx),
      .master_start_in(mstart), .master_busy_out(busy), .master_done_out(done), .master_rx_byte_out(m_rx),
      .autocfg_done_in(acfg), .slave_tx_byte_in(stx), .slave_tx_valid_in(stv), .slave_tx_ready_out(tx_ready),
      .slave_rx_byte_out(s_rx), .slave_rx_valid_out(s_valid));
   host_port_far_end far (.sclk_w_in(sclk_w), .mosi_w_in(mosi_w), .miso_w_in(miso_w), .cs_w_in(cs_w),
      .miso_drv_out(p_miso), .sclk_drv_out(p_sclk), .mosi_drv_out(p_mosi), .cs_drv_out(p_cs), .got_out(got));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize();
      if (fail_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
   endtask : tick
   // Bounded wait, leaves us just past an edge
   task automatic wait_hi(ref logic sig);
      for (int n = 0; n < 300 && sig !== 1'b1; n++) begin
         @(posedge mclk);
         #1;
      end
   endtask : wait_hi
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         summarize();
      end
   end
   // Falling edge keeps the count clear of the launching edge
   always @(negedge mclk) begin
      if (s_valid === 1'b1) begin
         rx_seen++;
      end
   end
   initial begin
      tick(3);
      rst <= 1'b0;
      foreach (rows[i]) begin
         tick(1);
         chip_n <= 1'b0;
         strap <= rows[i].strap;
         tick(6);
         chip_n <= 1'b1;
         pull_lo <= rows[i].pull;
         tick(8);
         #1;
         check({6'h0, mode}, {6'h0, rows[i].mode});
         check({6'h0, status}, {6'h0, rows[i].strap});
         check({7'h0, sda_d.oe}, {7'h0, rows[i].sda_oe});
         check({7'h0, sclk_d.oe}, {7'h0, rows[i].strap == 2'h3});
         check({7'h0, scl_lvl}, 8'h01);
         check({7'h0, sda_lvl}, {7'h0, ~rows[i].pull | rows[i].strap[1]});
      end
      tick(1);
      mtx <= 8'ha5;
      mstart <= 1'b1;
      tick(1);
      mstart <= 1'b0;
      #1;
      check({7'h0, busy}, 8'h01);
      wait_hi(done);
      check(m_rx, 8'h5a);
      check(got, 8'ha5);
      tick(1);
      acfg <= 1'b1;
      tick(1);
      acfg <= 1'b0;
      tick(5);
      #1;
      check({6'h0, mode}, {6'h0, host_port_pkg::MODE_SPI_SLAVE});
      check({7'h0, cs_d.oe}, 8'h00);
      // Hand-over needs one frame of link edges before its byte goes out
      wait_hi(tx_ready);
      tick(1);
      stx <= 8'hc3;
      stv <= 1'b1;
      tick(1);
      stv <= 1'b0;
      far.xfer(8'h3c, rx);
      check(rx, 8'hff);
      tick(8);
      #1;
      check(s_rx, 8'h3c);
      far.xfer(8'h69, rx);
      check(rx, 8'hc3);
      tick(8);
      #1;
      check(s_rx, 8'h69);
      check({7'h0, miso_d.oe}, 8'h00);
      check({7'h0, tx_ready}, 8'h01);
      check(8'(rx_seen), 8'h02);
      summarize();
   end
endmodule : host_port_pin_roles_bench
bind host_port_pin_roles host_port_pin_roles_sva #(.SCLK_HALF_CYC(SCLK_HALF_CYC)) chk (.mclk_in, .rst_in,
   .chip_reset_low_in, .miso_pin_in, .host_select_low_pin_in, .i2c_sda_pull_low_in, .master_start_in,
   .master_busy_out, .master_done_out, .autocfg_done_in, .sclk_drive_out, .sda_mosi_drive_out,
   .miso_drive_out, .host_select_low_drive_out, .iface_mode_out, .strap_capture_status_out);
`default_nettype wire
